// ### dma_chan_pkg.sv
// Package with register map, control fields, types and state of one channel.
package dma_chan_pkg;

  // ==========================================================================
  // Register indices as printed; the byte address is four times the index.
  localparam logic [31:0] IDX_CHAN0_ITEM_INDEX = 32'h5000360e;
  localparam logic [31:0] IDX_SOURCE_START_LOW = 32'h50003610;
  localparam logic [31:0] IDX_SOURCE_START_HIGH = 32'h50003612;
  localparam logic [31:0] IDX_DEST_START_LOW = 32'h50003614;
  localparam logic [31:0] IDX_DEST_START_HIGH = 32'h50003616;
  localparam logic [31:0] IDX_INTERRUPT_POINT = 32'h50003618;
  localparam logic [31:0] IDX_TRANSFER_LENGTH = 32'h5000361a;
  localparam logic [31:0] IDX_CHANNEL_CONTROL = 32'h5000361c;
  localparam logic [31:0] IDX_ITEM_INDEX = 32'h5000361e;
  localparam int ADDR_DECODE_W = 12;

  // ==========================================================================
  // Control register fields and reset values.
  localparam int CTRL_ON = 0;
  localparam int CTRL_WIDTH_LO = 1;
  localparam int CTRL_IRQ_EN = 3;
  localparam int CTRL_PERIPH_TRIG = 4;
  localparam int CTRL_DEST_INC = 5;
  localparam int CTRL_SRC_INC = 6;
  localparam int CTRL_CIRCULAR = 7;
  localparam int CTRL_PRIO_LO = 8;
  localparam int CTRL_IDLE_MODE = 11;
  localparam int CTRL_FILL = 12;
  localparam int CTRL_EDGE_SENSE = 13;
  localparam logic [15:0] CTRL_WRITE_MASK = 16'h3fff;
  localparam logic [15:0] REG_RESET = 16'h0000;

  // Item width codes.
  localparam logic [1:0] WIDTH_BYTE = 2'h0;
  localparam logic [1:0] WIDTH_HALF = 2'h1;
  localparam logic [1:0] WIDTH_WORD = 2'h2;

  // ==========================================================================
  // Types.
  typedef enum logic [2:0] {
    ST_IDLE, ST_ARB, ST_READ, ST_WRITE, ST_GAP
  } chan_phase_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [31:0] addr;
    logic [1:0] size;
    logic [31:0] wdata;
  } mem_req_t;

  typedef struct packed {
    logic [31:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    chan_phase_t phase;
    logic [15:0] srcLow;
    logic [15:0] srcHigh;
    logic [15:0] dstLow;
    logic [15:0] dstHigh;
    logic [15:0] intPoint;
    logic [15:0] xferLen;
    logic [15:0] ctrl;
    logic [15:0] itemIndex;
    logic reqPrev;
    logic reqPend;
    logic holdBus;
    logic [31:0] itemData;
    mem_req_t mem;
    logic irq;
    logic [31:0] prdata;
  } chan_state_t;

endpackage

// ### dma_channel_registers.sv
// One DMA channel: APB registers, request sensing, arbitration, copy engine.
`timescale 1ns/1ns
module dma_channel_registers #(
  parameter int NUM_CHANNELS = 4,
  parameter int CHANNEL_ID = 1
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic reset_n,
  // APB slave.
  input wire dma_chan_pkg::apb_req_t apbReq,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // System bus master port.
  output dma_chan_pkg::mem_req_t memReq,
  input wire logic memAck,
  input wire logic [31:0] memRdata,
  // Arbitration among channels.
  input wire logic [NUM_CHANNELS-1:0] peerRequest,
  input wire logic [NUM_CHANNELS-1:0][2:0] peerPriority,
  input wire logic peerLock,
  output logic busRequest,
  output logic busLock,
  output logic [2:0] channelPriority,
  // Peripheral request and other channel index.
  input wire logic periphRequest,
  input wire logic [15:0] chan0ItemIndex,
  // Channel interrupt, one-cycle pulse.
  output logic irqOut
);
  import dma_chan_pkg::*;

  chan_state_t state_ff;
  chan_state_t nxt_state;

  // ==========================================================================
  // Decoded control fields.
  logic chanOn;
  logic [1:0] itemWidth;
  logic irqEnable;
  logic periphTrig;
  logic destInc;
  logic srcInc;
  logic circular;
  logic idleMode;
  logic fillMode;
  logic edgeSense;
  logic [31:0] srcStart;
  logic [31:0] dstStart;
  logic [31:0] offset;
  logic [31:0] srcAddr;
  logic [31:0] dstAddr;
  logic trigger;
  logic winBus;
  logic lastItem;
  logic [ADDR_DECODE_W-1:0] decAddr;
  logic mapped;
  logic [15:0] readValue;

  assign chanOn = state_ff.ctrl[CTRL_ON];
  assign itemWidth = state_ff.ctrl[CTRL_WIDTH_LO +: 2];
  assign irqEnable = state_ff.ctrl[CTRL_IRQ_EN];
  assign periphTrig = state_ff.ctrl[CTRL_PERIPH_TRIG];
  assign destInc = state_ff.ctrl[CTRL_DEST_INC];
  assign srcInc = state_ff.ctrl[CTRL_SRC_INC];
  assign circular = state_ff.ctrl[CTRL_CIRCULAR];
  assign idleMode = state_ff.ctrl[CTRL_IDLE_MODE];
  assign fillMode = state_ff.ctrl[CTRL_FILL];
  assign edgeSense = state_ff.ctrl[CTRL_EDGE_SENSE];
  assign channelPriority = state_ff.ctrl[CTRL_PRIO_LO +: 3];

  // Start addresses are glued from their two halves.
  assign srcStart = {state_ff.srcHigh, state_ff.srcLow};
  assign dstStart = {state_ff.dstHigh, state_ff.dstLow};

  // Index scaled by item size; the reserved code steps like a byte.
  always_comb begin
    if (itemWidth == WIDTH_HALF) begin
      offset = {15'h0000, state_ff.itemIndex, 1'b0};
    end else if (itemWidth == WIDTH_WORD) begin
      offset = {14'h0000, state_ff.itemIndex, 2'b00};
    end else begin
      offset = {16'h0000, state_ff.itemIndex};
    end
  end

  // Fill mode ignores the source increment since only one fetch is done.
  assign srcAddr = (srcInc && !fillMode) ? srcStart + offset : srcStart;
  assign dstAddr = destInc ? dstStart + offset : dstStart;

  // The last item is the one whose index equals the programmed length.
  assign lastItem = (state_ff.itemIndex == state_ff.xferLen);

  // A request starts an item only in peripheral mode; level or stored edge.
  assign trigger = periphTrig && (edgeSense ? state_ff.reqPend : periphRequest);

  // ==========================================================================
  // Arbitration: lose to a higher priority, or equal priority and lower id.
  always_comb begin
    winBus = 1'b1;
    for (int j = 0; j < NUM_CHANNELS; j++) begin
      if (j != CHANNEL_ID && peerRequest[j]) begin
        if (peerPriority[j] > channelPriority) begin
          winBus = 1'b0;
        end else if (peerPriority[j] == channelPriority && j < CHANNEL_ID) begin
          winBus = 1'b0;
        end
      end
    end
  end

  assign busRequest = (state_ff.phase != ST_IDLE) && (state_ff.phase != ST_GAP);
  // A running fill holds the bus; blocking memory copies lock it too.
  assign busLock = state_ff.holdBus || (busRequest && !idleMode && !periphTrig);

  // ==========================================================================
  // APB decode on the low address bits of the byte address.
  function automatic logic [ADDR_DECODE_W-1:0] byteAddr(input logic [31:0] idx);
    byteAddr = {idx[ADDR_DECODE_W-3:0], 2'b00};
  endfunction

  assign decAddr = apbReq.paddr[ADDR_DECODE_W-1:0];

  always_comb begin
    mapped = 1'b1;
    readValue = REG_RESET;
    if (decAddr == byteAddr(IDX_CHAN0_ITEM_INDEX)) begin
      readValue = chan0ItemIndex;
    end else if (decAddr == byteAddr(IDX_SOURCE_START_LOW)) begin
      readValue = state_ff.srcLow;
    end else if (decAddr == byteAddr(IDX_SOURCE_START_HIGH)) begin
      readValue = state_ff.srcHigh;
    end else if (decAddr == byteAddr(IDX_DEST_START_LOW)) begin
      readValue = state_ff.dstLow;
    end else if (decAddr == byteAddr(IDX_DEST_START_HIGH)) begin
      readValue = state_ff.dstHigh;
    end else if (decAddr == byteAddr(IDX_INTERRUPT_POINT)) begin
      readValue = state_ff.intPoint;
    end else if (decAddr == byteAddr(IDX_TRANSFER_LENGTH)) begin
      readValue = state_ff.xferLen;
    end else if (decAddr == byteAddr(IDX_CHANNEL_CONTROL)) begin
      readValue = state_ff.ctrl;
    end else if (decAddr == byteAddr(IDX_ITEM_INDEX)) begin
      readValue = state_ff.itemIndex;
    end else begin
      mapped = 1'b0;
    end
  end

  // Read data is captured in the setup cycle, so no wait states are needed.
  assign pready = 1'b1;
  assign pslverr = apbReq.psel && apbReq.penable && !mapped;
  assign prdata = state_ff.prdata;
  assign memReq = state_ff.mem;
  assign irqOut = state_ff.irq;

  // ==========================================================================
  // Next state: register writes, request sensing and the copy sequence.
  always_comb begin
    logic apbWrite;
    logic itemDone;
    apbWrite = apbReq.psel && apbReq.penable && apbReq.pwrite;
    itemDone = 1'b0;
    nxt_state = state_ff;
    nxt_state.irq = 1'b0;
    nxt_state.reqPrev = periphRequest;

    // Register read data is sampled during the setup cycle.
    if (apbReq.psel && !apbReq.penable) begin
      nxt_state.prdata = {16'h0000, readValue};
    end

    // Rising edges are remembered in edge-sensed peripheral mode, even while an item is copied.
    if (periphTrig && edgeSense && periphRequest && !state_ff.reqPrev) begin
      nxt_state.reqPend = 1'b1;
    end

    // Copy engine; clocks are idle in effect while the channel is off.
    case (state_ff.phase)
      ST_IDLE: begin
        if (chanOn) begin
          if (!periphTrig) begin
            nxt_state.phase = ST_ARB;
          end else if (trigger) begin
            nxt_state.phase = ST_ARB;
            nxt_state.reqPend = 1'b0;
          end
        end
      end
      ST_ARB: begin
        if (state_ff.holdBus || (winBus && !peerLock)) begin
          nxt_state.mem.valid = 1'b1;
          nxt_state.mem.size = itemWidth;
          if (fillMode && state_ff.itemIndex != 16'h0000) begin
            // Later fill items reuse the single fetched value.
            nxt_state.phase = ST_WRITE;
            nxt_state.mem.write = 1'b1;
            nxt_state.mem.addr = dstAddr;
            nxt_state.mem.wdata = state_ff.itemData;
          end else begin
            nxt_state.phase = ST_READ;
            nxt_state.mem.write = 1'b0;
            nxt_state.mem.addr = srcAddr;
            nxt_state.holdBus = fillMode;
          end
        end
      end
      ST_READ: begin
        if (memAck) begin
          nxt_state.itemData = memRdata;
          nxt_state.phase = ST_WRITE;
          nxt_state.mem.write = 1'b1;
          nxt_state.mem.addr = dstAddr;
          nxt_state.mem.wdata = memRdata;
        end
      end
      ST_WRITE: begin
        if (memAck) begin
          nxt_state.mem.valid = 1'b0;
          nxt_state.mem.write = 1'b0;
          itemDone = 1'b1;
        end
      end
      ST_GAP: begin
        nxt_state.phase = ST_ARB;
      end
      default: begin
        nxt_state.phase = ST_IDLE;
      end
    endcase

    // Item completion: interrupt check comes before the index moves.
    if (itemDone) begin
      if (irqEnable && state_ff.intPoint == state_ff.itemIndex) begin
        nxt_state.irq = 1'b1;
      end
      if (lastItem) begin
        nxt_state.itemIndex = 16'h0000;
        nxt_state.holdBus = 1'b0;
        nxt_state.phase = ST_IDLE;
        if (!(circular && periphTrig)) begin
          nxt_state.ctrl[CTRL_ON] = 1'b0;
        end
      end else begin
        nxt_state.itemIndex = state_ff.itemIndex + 16'h0001;
        if (periphTrig) begin
          nxt_state.phase = ST_IDLE;
        end else if (idleMode) begin
          nxt_state.phase = ST_GAP;
        end else begin
          nxt_state.phase = ST_ARB;
        end
      end
    end

    // Register writes; a write to the control word overrides the self-clear.
    if (apbWrite) begin
      if (decAddr == byteAddr(IDX_SOURCE_START_LOW)) begin
        nxt_state.srcLow = apbReq.pwdata[15:0];
      end else if (decAddr == byteAddr(IDX_SOURCE_START_HIGH)) begin
        nxt_state.srcHigh = apbReq.pwdata[15:0];
      end else if (decAddr == byteAddr(IDX_DEST_START_LOW)) begin
        nxt_state.dstLow = apbReq.pwdata[15:0];
      end else if (decAddr == byteAddr(IDX_DEST_START_HIGH)) begin
        nxt_state.dstHigh = apbReq.pwdata[15:0];
      end else if (decAddr == byteAddr(IDX_INTERRUPT_POINT)) begin
        nxt_state.intPoint = apbReq.pwdata[15:0];
      end else if (decAddr == byteAddr(IDX_TRANSFER_LENGTH)) begin
        nxt_state.xferLen = apbReq.pwdata[15:0];
      end else if (decAddr == byteAddr(IDX_CHANNEL_CONTROL)) begin
        nxt_state.ctrl = apbReq.pwdata[15:0] & CTRL_WRITE_MASK;
      end
    end

    // Switching the channel off abandons the transfer and clears the index.
    if (!nxt_state.ctrl[CTRL_ON]) begin
      nxt_state.phase = ST_IDLE;
      nxt_state.itemIndex = 16'h0000;
      nxt_state.holdBus = 1'b0;
      nxt_state.reqPend = 1'b0;
      nxt_state.mem.valid = 1'b0;
      nxt_state.mem.write = 1'b0;
    end
  end

  // ==========================================================================
  // State register.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

endmodule // dma_channel_registers

// ### dma_channel_registers_chk.sv
// Checker of the DMA channel's ports, bound into the channel.
`timescale 1ns/1ns
module dma_channel_registers_chk #(
  parameter int NUM_CHANNELS = 4,
  parameter int CHANNEL_ID = 1
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic reset_n,
  // Register bus.
  input wire dma_chan_pkg::apb_req_t apbReq,
  input wire logic pslverr,
  // Memory port, arbitration and interrupt.
  input wire dma_chan_pkg::mem_req_t memReq,
  input wire logic memAck,
  input wire logic [NUM_CHANNELS-1:0] peerRequest,
  input wire logic [NUM_CHANNELS-1:0][2:0] peerPriority,
  input wire logic busRequest,
  input wire logic [2:0] channelPriority,
  input wire logic irqOut
);
  import dma_chan_pkg::*;
  logic ctrlWr;
  logic wrAck;
  logic lose;
  logic mapped;
  // ========
  // A control write may abort a transfer, so it excuses a dropped request.
  assign ctrlWr = apbReq.psel && apbReq.penable && apbReq.pwrite &&
    apbReq.paddr[11:0] == 12'h870;
  assign wrAck = memReq.valid && memReq.write && memAck;
  assign mapped = apbReq.paddr[11:0] inside {12'h838, 12'h840, 12'h848,
    12'h850, 12'h858, 12'h860, 12'h868, 12'h870, 12'h878};
  // A peer beats us on a higher level, or on a tie with a lower number.
  always_comb begin
    lose = 1'b0;
    for (int i = 0; i < NUM_CHANNELS; i++) begin
      if (i != CHANNEL_ID && peerRequest[i] &&
          (peerPriority[i] > channelPriority ||
          (peerPriority[i] == channelPriority && i < CHANNEL_ID))) begin
        lose = 1'b1;
      end
    end
  end
  // ========
  // Properties.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  sequence fetchDone;
    memReq.valid && !memReq.write && memAck && !ctrlWr;
  endsequence
  a_req_held: assert property (
    memReq.valid && !memAck && !ctrlWr |=> memReq.valid && $stable(memReq))
    else $error("memory request changed before its ack");
  a_store_follows: assert property (
    fetchDone |=> memReq.valid && memReq.write)
    else $error("no store right after a fetch");
  a_prio_field: assert property (
    ctrlWr |=> channelPriority == $past(apbReq.pwdata[10:8]))
    else $error("priority not taken from the control write");
  a_slave_error: assert property (
    apbReq.psel && apbReq.penable |-> pslverr == !mapped)
    else $error("error response does not match the map");
  a_irq_pulse: assert property (irqOut |=> !irqOut)
    else $error("interrupt longer than one cycle");
  a_irq_cause: assert property (
    $rose(irqOut) |-> $past(wrAck) || $past(wrAck, 2))
    else $error("interrupt without a finished store");
  a_arb_winner: assert property (
    $rose(memReq.valid) && !memReq.write |-> !$past(lose))
    else $error("fetch started while a peer held the grant");
  a_mem_needs_bus: assert property (
    memReq.valid |-> busRequest)
    else $error("memory request without a bus request");
endmodule // dma_channel_registers_chk

bind dma_channel_registers dma_channel_registers_chk #(
  .NUM_CHANNELS(NUM_CHANNELS), .CHANNEL_ID(CHANNEL_ID)
) dma_channel_registers_chk_inst (
  .clk_sys, .reset_n, .apbReq, .pslverr, .memReq, .memAck, .peerRequest,
  .peerPriority, .busRequest, .channelPriority, .irqOut
);

// ### dma_mem_model.sv
// Behavioural system bus memory that answers the channel's requests.
`timescale 1ns/1ns
module dma_mem_model (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic reset_n,
  // Request, chosen answer delay and the answer.
  input wire dma_chan_pkg::mem_req_t memReq,
  input wire logic [3:0] latency,
  output logic memAck,
  output logic [31:0] memRdata
);
  import dma_chan_pkg::*;
  logic [3:0] waitCnt;
  // ========
  // Answer after the chosen delay; between answers the data toggles, so a
  // stale value is never taken for a fresh fetch.
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      memAck <= 1'b0;
      waitCnt <= 4'h0;
      memRdata <= 32'h0;
    end else if (memAck || !memReq.valid) begin
      memAck <= 1'b0;
      waitCnt <= 4'h0;
      memRdata <= ~memRdata;
    end else if (waitCnt < latency) begin
      waitCnt <= waitCnt + 4'h1;
    end else begin
      memAck <= 1'b1;
      memRdata <= memReq.addr ^ 32'h5a5a0000;
    end
  end
endmodule // dma_mem_model

// ### dma_channel_registers_test.sv
// Self-checking testbench of one DMA channel against a memory model.
`timescale 1ns/1ns
module dma_channel_registers_test;
  import dma_chan_pkg::*;
  localparam logic [31:0] SRC = 32'h00011000;
  localparam logic [31:0] DST = 32'h00022000;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  apb_req_t apbReq = '0;
  mem_req_t memReq;
  logic [31:0] prdata, memRdata;
  logic pready, pslverr, memAck, busRequest, busLock, irqOut, errBit;
  logic [3:0] peerRequest = 4'h0;
  logic [3:0][2:0] peerPriority = '0;
  logic [2:0] channelPriority;
  logic periphRequest = 1'b0;
  logic [3:0] latency = 4'h2;
  logic [15:0] rdVal;
  logic [31:0] ra[$], wa[$], wd[$];
  int err_total = 0;
  int samples_checked = 0;
  int irqCount = 0;
  // ========
  // Clock, and logs of finished memory operations and interrupt pulses.
  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    if (irqOut === 1'b1) irqCount++;
    if (memAck === 1'b1 && memReq.valid === 1'b1) begin
      if (memReq.write) begin
        wa.push_back(memReq.addr);
        wd.push_back(memReq.wdata);
      end else ra.push_back(memReq.addr);
    end
  end
  dma_channel_registers #(.NUM_CHANNELS(4), .CHANNEL_ID(1))
    dma_channel_registers_inst (.clk_sys, .reset_n, .apbReq, .prdata,
    .pready, .pslverr, .memReq, .memAck, .memRdata, .peerRequest,
    .peerPriority, .peerLock(1'b0), .busRequest, .busLock, .channelPriority,
    .periphRequest, .chan0ItemIndex(16'h1234), .irqOut);
  dma_mem_model dma_mem_model_inst (.clk_sys, .reset_n, .memReq, .latency,
    .memAck, .memRdata);
  // ========
  // Shared tasks.
  task automatic chk(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask
  // The byte address is four times the register index; the channel decodes
  // only its low twelve bits, so the scaled value is passed on in full.
  function automatic logic [31:0] addrOf(input logic [31:0] idx);
    return {idx[29:0], 2'b00};
  endfunction
  task automatic apb(input logic [31:0] a, input logic w, input logic [15:0] d);
    apbReq <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w,
      pwdata: {16'h0, d}};
    @(posedge clk_sys);
    apbReq.penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rdVal = prdata[15:0];
    errBit = pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic wr(input logic [31:0] idx, input logic [15:0] d);
    apb(addrOf(idx), 1'b1, d);
  endtask
  task automatic rdExp(input logic [31:0] idx, input logic [15:0] e, string m);
    apb(addrOf(idx), 1'b0, 16'h0);
    chk(rdVal === e && errBit === 1'b0, m);
  endtask
  task automatic setup(input logic [15:0] len, input logic [15:0] ctrl);
    ra.delete();
    wa.delete();
    wd.delete();
    wr(IDX_TRANSFER_LENGTH, len);
    wr(IDX_CHANNEL_CONTROL, ctrl);
  endtask
  // Polls the enable bit; a bounded count keeps a stuck channel visible.
  task automatic waitOff();
    int n = 0;
    do begin
      apb(addrOf(IDX_CHANNEL_CONTROL), 1'b0, 16'h0);
      n++;
    end while (rdVal[0] !== 1'b0 && n < 100);
    chk(n < 100, "channel never finished");
  endtask
  // ========
  // Scenarios.
  task automatic sc_regs();
    logic [31:0] ix[8] = '{IDX_SOURCE_START_LOW, IDX_SOURCE_START_HIGH,
      IDX_DEST_START_LOW, IDX_DEST_START_HIGH, IDX_INTERRUPT_POINT,
      IDX_TRANSFER_LENGTH, IDX_CHANNEL_CONTROL, IDX_ITEM_INDEX};
    foreach (ix[i]) rdExp(ix[i], 16'h0, "reset value");
    wr(IDX_CHAN0_ITEM_INDEX, 16'h5555);
    wr(IDX_ITEM_INDEX, 16'h0007);
    rdExp(IDX_CHAN0_ITEM_INDEX, 16'h1234, "channel 0 index");
    rdExp(IDX_ITEM_INDEX, 16'h0, "index written");
    wr(IDX_SOURCE_START_LOW, SRC[15:0]);
    wr(IDX_SOURCE_START_HIGH, SRC[31:16]);
    wr(IDX_DEST_START_LOW, DST[15:0]);
    wr(IDX_DEST_START_HIGH, DST[31:16]);
    rdExp(IDX_SOURCE_START_HIGH, SRC[31:16], "source high");
    rdExp(IDX_DEST_START_LOW, DST[15:0], "dest low");
    wr(IDX_CHANNEL_CONTROL, 16'hfffe);
    rdExp(IDX_CHANNEL_CONTROL, 16'h3ffe, "control bits");
    wr(IDX_CHANNEL_CONTROL, 16'h0000);
    apb(32'h50000000, 1'b0, 16'h0);
    chk(errBit === 1'b1 && rdVal === 16'h0, "unmapped access");
  endtask
  task automatic sc_copy();
    int n = irqCount;
    wr(IDX_INTERRUPT_POINT, 16'h0001);
    setup(16'h0002, 16'h006d);
    waitOff();
    chk(wa.size() == 3, "item count");
    for (int k = 0; k < 3; k++) begin
      chk(ra[k] === SRC + 4 * k, "source address");
      chk(wa[k] === DST + 4 * k, "dest address");
      chk(wd[k] === ((SRC + 4 * k) ^ 32'h5a5a0000), "copied data");
    end
    chk(irqCount == n + 1, "interrupt count");
    rdExp(IDX_ITEM_INDEX, 16'h0, "index not cleared");
    rdExp(IDX_CHANNEL_CONTROL, 16'h006c, "enable not cleared");
  endtask
  task automatic sc_width();
    int n = irqCount;
    latency <= 4'h0;
    periphRequest <= 1'b1;
    for (int w = 0; w < 3; w++) begin
      setup(16'h0001, 16'h0821 | 16'(w << 1));
      waitOff();
      chk(ra[1] === SRC, "source moved");
      chk(wa[1] === DST + (1 << w), "dest step");
    end
    periphRequest <= 1'b0;
    chk(irqCount == n, "interrupt while disabled");
  endtask
  task automatic sc_fill();
    latency <= 4'h3;
    setup(16'h0002, 16'h1065);
    wait (ra.size() != 0);
    @(posedge clk_sys);
    peerPriority[0] <= 3'h7;
    peerRequest <= 4'h1;
    waitOff();
    peerRequest <= 4'h0;
    chk(ra.size() == 1 && wa.size() == 3, "fill counts");
    for (int k = 0; k < 3; k++) begin
      chk(wa[k] === DST + 4 * k, "fill address");
      chk(wd[k] === (SRC ^ 32'h5a5a0000), "fill value");
    end
  endtask
  task automatic sc_periph();
    latency <= 4'h0;
    setup(16'h0001, 16'h20b5);
    repeat (20) @(posedge clk_sys);
    chk(wa.size() == 0, "start without request");
    periphRequest <= 1'b1;
    repeat (30) @(posedge clk_sys);
    chk(wa.size() == 1, "one item per edge");
    periphRequest <= 1'b0;
    @(posedge clk_sys);
    periphRequest <= 1'b1;
    repeat (30) @(posedge clk_sys);
    chk(wa.size() == 2, "second edge");
    rdExp(IDX_CHANNEL_CONTROL, 16'h20b5, "circular stopped");
    wr(IDX_CHANNEL_CONTROL, 16'h0000);
    setup(16'h0001, 16'h08b5);
    repeat (30) @(posedge clk_sys);
    chk(wa.size() > 2 && wa[2] === DST, "level restart");
    wr(IDX_CHANNEL_CONTROL, 16'h0000);
    periphRequest <= 1'b0;
  endtask
  task automatic sc_arb();
    peerPriority[0] <= 3'h5;
    peerPriority[2] <= 3'h3;
    peerRequest <= 4'h5;
    setup(16'h0000, 16'h0305);
    repeat (20) @(posedge clk_sys);
    chk(ra.size() == 0, "higher peer lost");
    chk(busLock === 1'b1, "no bus lock in blocking copy");
    peerPriority[0] <= 3'h3;
    repeat (20) @(posedge clk_sys);
    chk(ra.size() == 0, "tie not to channel 0");
    peerPriority[0] <= 3'h2;
    waitOff();
    chk(wa.size() == 1, "grant missing");
    peerRequest <= 4'h0;
  endtask
  // ========
  // Verdict, main sequence and watchdog.
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    sc_regs();
    sc_copy();
    sc_width();
    sc_fill();
    sc_periph();
    sc_arb();
    report_and_stop();
  end
  initial begin
    #2000000;
    err_total++;
    report_and_stop();
  end
endmodule // dma_channel_registers_test
